//--- design/otdrc_pkg.sv
// constants, encodings and reset values for the oscillator trim and dco range control
package otdrc_pkg;

   // register offsets
   localparam logic [3:0] OFFSET_OSC_RANGE_CTRL = 4'h1;
   localparam logic [3:0] OFFSET_SLOW_TRIM      = 4'h2;
   localparam logic [3:0] OFFSET_FAST_TRIM_DCO  = 4'h3;

   // oscillator_range_control fields
   localparam int BIT_LOC_RESET_SEL   = 7;
   localparam int BIT_OSC_RESERVED    = 6;
   localparam int BIT_OSC_RANGE_HI    = 5;
   localparam int BIT_OSC_RANGE_LO    = 4;
   localparam int BIT_HIGH_GAIN       = 3;
   localparam int BIT_EXT_REF_SEL     = 2;
   localparam int BIT_LOW_POWER       = 1;
   localparam int BIT_IREF_SPEED      = 0;

   // fast_trim_and_dco_range fields
   localparam int BIT_DCO_MAX_FREQ    = 7;
   localparam int BIT_DCO_RANGE_HI    = 6;
   localparam int BIT_DCO_RANGE_LO    = 5;
   localparam int BIT_FAST_TRIM_HI    = 4;
   localparam int BIT_FAST_TRIM_LO    = 1;
   localparam int BIT_SLOW_FINE_TRIM  = 0;

   // reset values
   localparam logic       RST_LOC_RESET_SEL = 1'b1;
   localparam logic [1:0] RST_OSC_RANGE     = 2'h0;
   localparam logic       RST_BIT_CLEAR     = 1'b0;
   localparam logic [1:0] RST_DCO_RANGE     = 2'h0;
   localparam logic [7:0] READ_ZERO         = 8'h00;

   // oscillator range and dco range encodings
   localparam logic [1:0] OSC_RANGE_LOW     = 2'h0;
   localparam logic [1:0] OSC_RANGE_HIGH    = 2'h1;
   localparam logic [1:0] DCO_RANGE_LOW     = 2'h0;
   localparam logic [1:0] DCO_RANGE_MID     = 2'h1;
   localparam logic [1:0] DCO_RANGE_MIDHIGH = 2'h2;
   localparam logic [1:0] DCO_RANGE_HIGH    = 2'h3;

   // fll multiplication factors
   localparam logic [11:0] FLL_BASE_FACTOR  = 12'd640;
   localparam logic [11:0] FLL_ONE          = 12'd1;
   localparam logic [11:0] FLL_MAX_FACTOR0  = 12'd732;
   localparam logic [11:0] FLL_MAX_FACTOR1  = 12'd1464;
   localparam logic [11:0] FLL_MAX_FACTOR2  = 12'd2197;
   localparam logic [11:0] FLL_MAX_FACTOR3  = 12'd2929;

   // range synchroniser depth
   localparam int SYNC_STAGES = 2;

   // clock generator modes
   typedef enum logic [3:0] {
      OTDRC_MODE_FEI      = 4'h0,
      OTDRC_MODE_FEE      = 4'h1,
      OTDRC_MODE_FBYP_INT = 4'h2,
      OTDRC_MODE_FBYP_EXT = 4'h3,
      OTDRC_MODE_PBYP_EXT = 4'h4,
      OTDRC_MODE_PEE      = 4'h5,
      OTDRC_MODE_LBYP_INT = 4'h6,
      OTDRC_MODE_LBYP_EXT = 4'h7,
      OTDRC_MODE_STOP     = 4'h8
   } otdrc_mode_t;

endpackage : otdrc_pkg

//--- design/otdrc_sync.sv
// multi-flop synchroniser chain for a small word
`timescale 1ns/1ns
module otdrc_sync #(
   parameter int W      = 2,
   parameter int STAGES = 2
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // data
   input  wire logic [W-1:0] din,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] dout
);

   logic [W-1:0] stage [STAGES];

   // only the last stage is read outside the chain
   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : g_stage
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               stage[g] <= '0;
            end else if (g == 0) begin
               stage[g] <= din;
            end else begin
               stage[g] <= stage[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   assign dout = stage[STAGES-1] | (rst_val & '0);

endmodule : otdrc_sync

//--- design/otdrc_ctrl.sv
// oscillator range, reference trims and dco range control registers
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////////////////////
// What this block does
// - bit 7 chooses interrupt when clear, reset request when set, on lost oscillator
// - the response choice acts only while the clock monitor is enabled
// - bit 6 of oscillator control always reads zero, writes ignored
// - range field bits 5-4: 00 low, 01 high, 1X very high
// - bit 3 selects low-power when clear, high gain when set
// - bit 2 requests external clock when clear, crystal oscillator when set
// - low-power bit set disables the loop in low-power bypass modes
// - low-power bit moves bypassed external/internal modes into low-power bypass modes
// - bit 0 selects slow internal reference when clear, fast when set
// - eight-bit slow coarse trim is binary weighted, larger means longer period
// - slow coarse trim is loaded from factory value at reset
// - fine trim bit set lengthens slow period one step, clear shortens
// - four-bit fast trim binary weighted, larger is longer, factory loaded at reset
// - slow fine trim bit is also loaded from factory value at reset
// - reset clears dco range and maximum-frequency option
// - dco range 00 low, 01 mid, 10 mid-high, 11 high
// - writes to dco range are dropped while low-power bit is set
// - dco range reads return the synchronised range in effect
// - fll factor 640*(range+1), or 732/1464/2197/2929 with maximum-frequency set
// - maximum-frequency bit tunes dco for a 32.768 kHz reference
// - monitor enable arms loss detection, outcome chosen by response bit
// - writes only in supervisor mode, user writes to the three registers get bus error, reads always
module otdrc_ctrl (
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   // register port
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic        REG_SUPERVISOR,
   output logic      [7:0]  REG_RDATA,
   output logic             REG_BUS_ERROR,
   // factory trim values
   input  wire logic [7:0]  FACTORY_SLOW_COARSE_TRIM,
   input  wire logic        FACTORY_SLOW_FINE_TRIM,
   input  wire logic [3:0]  FACTORY_FAST_TRIM,
   // clock monitor and mode
   input  wire logic        EXTERNAL_CLOCK_MONITOR_ENABLE,
   input  wire logic        OSC_CLOCK_LOST,
   input  wire logic [3:0]  CURRENT_MODE,
   // oscillator controls
   output logic      [1:0]  OSCILLATOR_FREQUENCY_RANGE,
   output logic             OSCILLATOR_VERY_HIGH_RANGE,
   output logic             OSCILLATOR_HIGH_GAIN_SELECT,
   output logic             EXTERNAL_REFERENCE_SOURCE_SELECT,
   output logic             INTERNAL_REFERENCE_SPEED_SELECT,
   // trims
   output logic      [7:0]  SLOW_REFERENCE_COARSE_TRIM,
   output logic             SLOW_REFERENCE_FINE_TRIM,
   output logic      [3:0]  FAST_REFERENCE_TRIM,
   // loop and dco
   output logic             LOOP_DISABLE,
   output logic      [3:0]  MODE_REQUEST,
   output logic      [1:0]  DCO_RANGE_SELECT,
   output logic      [1:0]  DCO_RANGE_STATUS,
   output logic             DCO_MAX_FREQUENCY_OPTION,
   output logic      [11:0] FLL_FACTOR,
   // loss of clock responses
   output logic             LOSS_OF_CLOCK_IRQ,
   output logic             LOSS_OF_CLOCK_RESET_REQ
);

   //////////////////////////////////////////////////////////////////////////////////////////
   // storage

   logic        loss_of_clock_reset_select;
   logic [1:0]  oscillator_frequency_range;
   logic        oscillator_high_gain_select;
   logic        external_reference_source_select;
   logic        bypass_low_power_select;
   logic        internal_reference_speed_select;
   logic [7:0]  slow_reference_coarse_trim;
   logic        slow_reference_fine_trim;
   logic [3:0]  fast_reference_trim;
   logic        dco_max_frequency_option;
   logic [1:0]  dco_range_select;
   logic        factory_loaded;
   logic [7:0]  rdata;
   logic        bus_error;
   logic        loc_irq;
   logic        loc_reset;
   logic [11:0] fll_factor;
   logic [3:0]  mode_request;

   //////////////////////////////////////////////////////////////////////////////////////////
   // address decode and access checks

   wire hit_osc  = (REG_ADDR == otdrc_pkg::OFFSET_OSC_RANGE_CTRL);
   wire hit_slow = (REG_ADDR == otdrc_pkg::OFFSET_SLOW_TRIM);
   wire hit_fast = (REG_ADDR == otdrc_pkg::OFFSET_FAST_TRIM_DCO);
   wire hit_any  = hit_osc | hit_slow | hit_fast;

   wire wr_ok    = REG_WR & REG_SUPERVISOR;
   wire wr_user  = REG_WR & ~REG_SUPERVISOR & hit_any;

   wire wr_osc   = wr_ok & hit_osc;
   wire wr_slow  = wr_ok & hit_slow;
   wire wr_fast  = wr_ok & hit_fast;
   wire wr_range = wr_fast & ~bypass_low_power_select;

   wire [1:0] wdata_dco = REG_WDATA[otdrc_pkg::BIT_DCO_RANGE_HI:otdrc_pkg::BIT_DCO_RANGE_LO];
   wire [1:0] wdata_rng = REG_WDATA[otdrc_pkg::BIT_OSC_RANGE_HI:otdrc_pkg::BIT_OSC_RANGE_LO];
   wire [3:0] wdata_ftr = REG_WDATA[otdrc_pkg::BIT_FAST_TRIM_HI:otdrc_pkg::BIT_FAST_TRIM_LO];

   //////////////////////////////////////////////////////////////////////////////////////////
   // dco range synchronised there and back

   logic [1:0] dco_range_applied;
   logic [1:0] dco_range_status;

   otdrc_sync #(
      .W      (2),
      .STAGES (otdrc_pkg::SYNC_STAGES)
   ) u_sync_there (
      .clk     (SYS_CLK),
      .rst_b   (RST_B),
      .din     (dco_range_select),
      .rst_val (otdrc_pkg::RST_DCO_RANGE),
      .dout    (dco_range_applied)
   );

   otdrc_sync #(
      .W      (2),
      .STAGES (otdrc_pkg::SYNC_STAGES)
   ) u_sync_back (
      .clk     (SYS_CLK),
      .rst_b   (RST_B),
      .din     (dco_range_applied),
      .rst_val (otdrc_pkg::RST_DCO_RANGE),
      .dout    (dco_range_status)
   );

   //////////////////////////////////////////////////////////////////////////////////////////
   // read data

   wire [7:0] rd_osc = {
      loss_of_clock_reset_select,
      1'b0,
      oscillator_frequency_range,
      oscillator_high_gain_select,
      external_reference_source_select,
      bypass_low_power_select,
      internal_reference_speed_select
   };

   wire [7:0] rd_fast = {
      dco_max_frequency_option,
      dco_range_status,
      fast_reference_trim,
      slow_reference_fine_trim
   };

   wire [7:0] next_rdata = !REG_RD  ? otdrc_pkg::READ_ZERO :
                           hit_osc  ? rd_osc :
                           hit_slow ? slow_reference_coarse_trim :
                           hit_fast ? rd_fast : otdrc_pkg::READ_ZERO;

   //////////////////////////////////////////////////////////////////////////////////////////
   // fll factor from the range in effect

   logic [11:0] next_fll_factor;

   always_comb begin
      next_fll_factor = 12'(otdrc_pkg::FLL_BASE_FACTOR *
                            (12'(dco_range_applied) + otdrc_pkg::FLL_ONE));
      if (dco_max_frequency_option) begin
         unique case (dco_range_applied)
            otdrc_pkg::DCO_RANGE_LOW:     next_fll_factor = otdrc_pkg::FLL_MAX_FACTOR0;
            otdrc_pkg::DCO_RANGE_MID:     next_fll_factor = otdrc_pkg::FLL_MAX_FACTOR1;
            otdrc_pkg::DCO_RANGE_MIDHIGH: next_fll_factor = otdrc_pkg::FLL_MAX_FACTOR2;
            otdrc_pkg::DCO_RANGE_HIGH:    next_fll_factor = otdrc_pkg::FLL_MAX_FACTOR3;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // mode transition request from the low-power bit

   otdrc_pkg::otdrc_mode_t cur_mode;
   logic [3:0]             next_mode_request;

   assign cur_mode = otdrc_pkg::otdrc_mode_t'(CURRENT_MODE);

   always_comb begin
      next_mode_request = CURRENT_MODE;
      if (bypass_low_power_select) begin
         unique case (cur_mode)
            otdrc_pkg::OTDRC_MODE_FBYP_EXT,
            otdrc_pkg::OTDRC_MODE_PBYP_EXT: next_mode_request = otdrc_pkg::OTDRC_MODE_LBYP_EXT;
            otdrc_pkg::OTDRC_MODE_FBYP_INT: next_mode_request = otdrc_pkg::OTDRC_MODE_LBYP_INT;
            default:                        next_mode_request = CURRENT_MODE;
         endcase
      end
   end

   // loop is off only in the low-power bypass modes while the bit is set
   wire in_low_bypass = (cur_mode == otdrc_pkg::OTDRC_MODE_LBYP_EXT) |
                        (cur_mode == otdrc_pkg::OTDRC_MODE_LBYP_INT);
   wire next_loop_disable = bypass_low_power_select & in_low_bypass;

   //////////////////////////////////////////////////////////////////////////////////////////
   // loss of clock response

   wire loss_seen = OSC_CLOCK_LOST & EXTERNAL_CLOCK_MONITOR_ENABLE;
   wire next_loc_irq   = loss_seen & ~loss_of_clock_reset_select;
   wire next_loc_reset = loss_seen & loss_of_clock_reset_select;

   //////////////////////////////////////////////////////////////////////////////////////////
   // oscillator_range_control

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         loss_of_clock_reset_select       <= otdrc_pkg::RST_LOC_RESET_SEL;
         oscillator_frequency_range       <= otdrc_pkg::RST_OSC_RANGE;
         oscillator_high_gain_select      <= otdrc_pkg::RST_BIT_CLEAR;
         external_reference_source_select <= otdrc_pkg::RST_BIT_CLEAR;
         bypass_low_power_select          <= otdrc_pkg::RST_BIT_CLEAR;
         internal_reference_speed_select  <= otdrc_pkg::RST_BIT_CLEAR;
      end else if (wr_osc) begin
         loss_of_clock_reset_select       <= REG_WDATA[otdrc_pkg::BIT_LOC_RESET_SEL];
         oscillator_frequency_range       <= wdata_rng;
         oscillator_high_gain_select      <= REG_WDATA[otdrc_pkg::BIT_HIGH_GAIN];
         external_reference_source_select <= REG_WDATA[otdrc_pkg::BIT_EXT_REF_SEL];
         bypass_low_power_select          <= REG_WDATA[otdrc_pkg::BIT_LOW_POWER];
         internal_reference_speed_select  <= REG_WDATA[otdrc_pkg::BIT_IREF_SPEED];
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // trims: factory values caught on the first edge after reset release

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         factory_loaded <= 1'b0;
      end else begin
         factory_loaded <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         slow_reference_coarse_trim <= otdrc_pkg::READ_ZERO;
      end else if (!factory_loaded) begin
         slow_reference_coarse_trim <= FACTORY_SLOW_COARSE_TRIM;
      end else if (wr_slow) begin
         slow_reference_coarse_trim <= REG_WDATA;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         slow_reference_fine_trim <= otdrc_pkg::RST_BIT_CLEAR;
         fast_reference_trim      <= '0;
      end else if (!factory_loaded) begin
         slow_reference_fine_trim <= FACTORY_SLOW_FINE_TRIM;
         fast_reference_trim      <= FACTORY_FAST_TRIM;
      end else if (wr_fast) begin
         slow_reference_fine_trim <= REG_WDATA[otdrc_pkg::BIT_SLOW_FINE_TRIM];
         fast_reference_trim      <= wdata_ftr;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // dco range select and maximum-frequency option

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dco_max_frequency_option <= otdrc_pkg::RST_BIT_CLEAR;
      end else if (wr_fast) begin
         dco_max_frequency_option <= REG_WDATA[otdrc_pkg::BIT_DCO_MAX_FREQ];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dco_range_select <= otdrc_pkg::RST_DCO_RANGE;
      end else if (wr_range) begin
         dco_range_select <= wdata_dco;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // registered outputs

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata        <= otdrc_pkg::READ_ZERO;
         bus_error    <= 1'b0;
         loc_irq      <= 1'b0;
         loc_reset    <= 1'b0;
         fll_factor   <= otdrc_pkg::FLL_BASE_FACTOR;
         mode_request <= otdrc_pkg::OTDRC_MODE_FEI;
      end else begin
         rdata        <= next_rdata;
         bus_error    <= wr_user;
         loc_irq      <= next_loc_irq;
         loc_reset    <= next_loc_reset;
         fll_factor   <= next_fll_factor;
         mode_request <= next_mode_request;
      end
   end

   logic loop_disable;

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         loop_disable <= 1'b0;
      end else begin
         loop_disable <= next_loop_disable;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // output drive

   assign REG_RDATA                        = rdata;
   assign REG_BUS_ERROR                    = bus_error;
   assign OSCILLATOR_FREQUENCY_RANGE       = oscillator_frequency_range;
   // any 1X pattern is the very high range
   assign OSCILLATOR_VERY_HIGH_RANGE       = oscillator_frequency_range[1];
   assign OSCILLATOR_HIGH_GAIN_SELECT      = oscillator_high_gain_select;
   assign EXTERNAL_REFERENCE_SOURCE_SELECT = external_reference_source_select;
   assign INTERNAL_REFERENCE_SPEED_SELECT  = internal_reference_speed_select;
   assign SLOW_REFERENCE_COARSE_TRIM       = slow_reference_coarse_trim;
   assign SLOW_REFERENCE_FINE_TRIM         = slow_reference_fine_trim;
   assign FAST_REFERENCE_TRIM              = fast_reference_trim;
   assign LOOP_DISABLE                     = loop_disable;
   assign MODE_REQUEST                     = mode_request;
   assign DCO_RANGE_SELECT                 = dco_range_select;
   assign DCO_RANGE_STATUS                 = dco_range_status;
   assign DCO_MAX_FREQUENCY_OPTION         = dco_max_frequency_option;
   assign FLL_FACTOR                       = fll_factor;
   assign LOSS_OF_CLOCK_IRQ                = loc_irq;
   assign LOSS_OF_CLOCK_RESET_REQ          = loc_reset;

endmodule : otdrc_ctrl

//--- testbench/otdrc_ctrl_asserts.sv
// concurrent checks on the ports of the oscillator trim and dco range control block
`timescale 1ns/1ns
module otdrc_ctrl_asserts (
   // clock and reset
   input wire logic        SYS_CLK,
   input wire logic        RST_B,
   // register port
   input wire logic [3:0]  REG_ADDR,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic        REG_SUPERVISOR,
   input wire logic [7:0]  REG_RDATA,
   input wire logic        REG_BUS_ERROR,
   // factory values and trims
   input wire logic [7:0]  FACTORY_SLOW_COARSE_TRIM,
   input wire logic        FACTORY_SLOW_FINE_TRIM,
   input wire logic [3:0]  FACTORY_FAST_TRIM,
   input wire logic [7:0]  SLOW_REFERENCE_COARSE_TRIM,
   input wire logic        SLOW_REFERENCE_FINE_TRIM,
   input wire logic [3:0]  FAST_REFERENCE_TRIM,
   // monitor, mode and dco
   input wire logic        EXTERNAL_CLOCK_MONITOR_ENABLE,
   input wire logic        OSC_CLOCK_LOST,
   input wire logic [3:0]  CURRENT_MODE,
   input wire logic [3:0]  MODE_REQUEST,
   input wire logic        LOOP_DISABLE,
   input wire logic [1:0]  DCO_RANGE_SELECT,
   input wire logic [1:0]  DCO_RANGE_STATUS,
   input wire logic        DCO_MAX_FREQUENCY_OPTION,
   input wire logic [11:0] FLL_FACTOR,
   input wire logic        LOSS_OF_CLOCK_IRQ,
   input wire logic        LOSS_OF_CLOCK_RESET_REQ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   wire user_hit = REG_WR && !REG_SUPERVISOR && REG_ADDR != 4'h0 && REG_ADDR < 4'h4;
   wire lost_hit = OSC_CLOCK_LOST && EXTERNAL_CLOCK_MONITOR_ENABLE;
   function automatic logic [11:0] fll(logic [1:0] r, logic m);
      logic [11:0] tab [4] = '{12'd732, 12'd1464, 12'd2197, 12'd2929};
      return m ? tab[r] : 12'd640 * (12'(r) + 12'd1);
   endfunction : fll
   rsvd_zero_a: assert property (REG_RD && REG_ADDR == 4'h1 |=> !REG_RDATA[6])
      else $error("reserved bit read as one");
   bus_err_a: assert property (user_hit |=> REG_BUS_ERROR)
      else $error("user write gave no bus error");
   no_err_a: assert property (!user_hit |=> !REG_BUS_ERROR)
      else $error("bus error without user write");
   user_keep_a: assert property (REG_WR && !REG_SUPERVISOR |=>
      $stable(SLOW_REFERENCE_COARSE_TRIM) && $stable(DCO_RANGE_SELECT))
      else $error("user write changed a register");
   resp_one_a: assert property (!(LOSS_OF_CLOCK_IRQ && LOSS_OF_CLOCK_RESET_REQ))
      else $error("both loss responses raised");
   resp_hit_a: assert property (lost_hit |=> LOSS_OF_CLOCK_IRQ || LOSS_OF_CLOCK_RESET_REQ)
      else $error("lost clock gave no response");
   resp_off_a: assert property (!lost_hit |=>
      !LOSS_OF_CLOCK_IRQ && !LOSS_OF_CLOCK_RESET_REQ)
      else $error("loss response without cause");
   mode_pass_a: assert property (!(CURRENT_MODE inside {4'h2, 4'h3, 4'h4}) |=>
      MODE_REQUEST == $past(CURRENT_MODE)) else $error("mode request altered");
   loop_off_a: assert property (!(CURRENT_MODE inside {4'h6, 4'h7}) |=> !LOOP_DISABLE)
      else $error("loop disabled outside low power bypass");
   range_sync_a: assert property ($stable(DCO_RANGE_SELECT) [*4] |->
      DCO_RANGE_STATUS == DCO_RANGE_SELECT) else $error("range status not following");
   fll_a: assert property (
      ($stable(DCO_RANGE_SELECT) && $stable(DCO_MAX_FREQUENCY_OPTION)) [*4]
      |-> FLL_FACTOR == fll(DCO_RANGE_SELECT, DCO_MAX_FREQUENCY_OPTION))
      else $error("wrong loop factor");
   rst_clear_a: assert property ($rose(RST_B) |-> DCO_RANGE_SELECT == 2'h0
      && !DCO_MAX_FREQUENCY_OPTION) else $error("dco fields not cleared");
   factory_a: assert property ($rose(RST_B) |=>
      SLOW_REFERENCE_COARSE_TRIM == $past(FACTORY_SLOW_COARSE_TRIM)
      && SLOW_REFERENCE_FINE_TRIM == $past(FACTORY_SLOW_FINE_TRIM)
      && FAST_REFERENCE_TRIM == $past(FACTORY_FAST_TRIM)) else $error("trims not loaded");
   cover property (REG_BUS_ERROR);
   cover property (LOSS_OF_CLOCK_RESET_REQ);
   cover property (DCO_RANGE_STATUS == 2'h3 && DCO_MAX_FREQUENCY_OPTION);
endmodule : otdrc_ctrl_asserts

//--- testbench/tb.sv
// self-checking bench for the oscillator trim and dco range control block
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
   logic SYS_CLK = 1'b0, RST_B = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, REG_SUPERVISOR = 1'b0;
   logic EXTERNAL_CLOCK_MONITOR_ENABLE = 1'b0, OSC_CLOCK_LOST = 1'b0;
   logic FACTORY_SLOW_FINE_TRIM = 1'b0;
   logic [3:0] REG_ADDR = 4'h0, CURRENT_MODE = 4'h0, FACTORY_FAST_TRIM = 4'h0;
   logic [7:0] REG_WDATA = 8'h00, FACTORY_SLOW_COARSE_TRIM = 8'h00;
   wire logic [7:0] REG_RDATA, SLOW_REFERENCE_COARSE_TRIM;
   wire logic [3:0] FAST_REFERENCE_TRIM, MODE_REQUEST;
   wire logic [1:0] OSCILLATOR_FREQUENCY_RANGE, DCO_RANGE_SELECT, DCO_RANGE_STATUS;
   wire logic [11:0] FLL_FACTOR;
   wire logic REG_BUS_ERROR, OSCILLATOR_VERY_HIGH_RANGE, OSCILLATOR_HIGH_GAIN_SELECT;
   wire logic EXTERNAL_REFERENCE_SOURCE_SELECT, INTERNAL_REFERENCE_SPEED_SELECT, LOOP_DISABLE;
   wire logic SLOW_REFERENCE_FINE_TRIM, DCO_MAX_FREQUENCY_OPTION;
   wire logic LOSS_OF_CLOCK_IRQ, LOSS_OF_CLOCK_RESET_REQ;
   int seed = 72, mismatches = 0, comparisons = 0, cyc = 0;
   // shadow of the register contents
   logic [7:0] osc, slow;
   logic [3:0] fast;
   logic [1:0] rng;
   logic mx, fine, hit;
   logic [31:0] r;
   otdrc_ctrl dut_u (.SYS_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
      .REG_SUPERVISOR, .REG_RDATA, .REG_BUS_ERROR, .FACTORY_SLOW_COARSE_TRIM,
      .FACTORY_SLOW_FINE_TRIM, .FACTORY_FAST_TRIM, .EXTERNAL_CLOCK_MONITOR_ENABLE,
      .OSC_CLOCK_LOST, .CURRENT_MODE, .OSCILLATOR_FREQUENCY_RANGE, .OSCILLATOR_VERY_HIGH_RANGE,
      .OSCILLATOR_HIGH_GAIN_SELECT, .EXTERNAL_REFERENCE_SOURCE_SELECT,
      .INTERNAL_REFERENCE_SPEED_SELECT, .SLOW_REFERENCE_COARSE_TRIM, .SLOW_REFERENCE_FINE_TRIM,
      .FAST_REFERENCE_TRIM, .LOOP_DISABLE, .MODE_REQUEST, .DCO_RANGE_SELECT, .DCO_RANGE_STATUS,
      .DCO_MAX_FREQUENCY_OPTION, .FLL_FACTOR, .LOSS_OF_CLOCK_IRQ, .LOSS_OF_CLOCK_RESET_REQ);
   initial begin
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         wrap_up();
      end
   end
   function automatic logic [11:0] fll(logic [1:0] g, logic m);
      logic [11:0] tab [4] = '{12'd732, 12'd1464, 12'd2197, 12'd2929};
      return m ? tab[g] : 12'd640 * (12'(g) + 12'd1);
   endfunction : fll
   function automatic logic [7:0] exp_rd(logic [3:0] a);
      case (a)
         4'h1: return osc;
         4'h2: return slow;
         4'h3: return {mx, rng, fast, fine};
         default: return 8'h00;
      endcase
   endfunction : exp_rd
   function automatic logic [3:0] exp_mode(logic [3:0] m);
      if (osc[1] && (m == 4'h3 || m == 4'h4)) return 4'h7;
      if (osc[1] && m == 4'h2) return 4'h6;
      return m;
   endfunction : exp_mode
   task wrap_up;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////////////////
   task do_rst;
      @(posedge SYS_CLK);
      RST_B <= 1'b0;
      FACTORY_SLOW_COARSE_TRIM <= 8'($random(seed));
      FACTORY_FAST_TRIM <= 4'($random(seed));
      FACTORY_SLOW_FINE_TRIM <= 1'($random(seed));
      repeat (5) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      @(posedge SYS_CLK);
      osc = 8'h80;
      {slow, fast, fine} = {FACTORY_SLOW_COARSE_TRIM, FACTORY_FAST_TRIM, FACTORY_SLOW_FINE_TRIM};
      {rng, mx} = 3'h0;
   endtask : do_rst
   task wr(input logic [3:0] a, input logic [7:0] d, input logic s);
      @(posedge SYS_CLK);
      {REG_ADDR, REG_WDATA, REG_WR, REG_SUPERVISOR} <= {a, d, 1'b1, s};
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
      #1 `CHK(REG_BUS_ERROR, 1'(!s && a != 4'h0 && a < 4'h4))
      if (s && a == 4'h1) osc = d & 8'hBF;
      if (s && a == 4'h2) slow = d;
      if (s && a == 4'h3) begin
         if (!osc[1]) rng = d[6:5];
         {mx, fast, fine} = {d[7], d[4:0]};
      end
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      {REG_ADDR, REG_RD} <= {a, 1'b1};
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 `CHK(REG_RDATA, exp_rd(a))
   endtask : rd
   task chk_ports;
      hit = OSC_CLOCK_LOST && EXTERNAL_CLOCK_MONITOR_ENABLE;
      `CHK({OSCILLATOR_VERY_HIGH_RANGE, OSCILLATOR_FREQUENCY_RANGE}, {osc[5], osc[5:4]})
      `CHK(OSCILLATOR_HIGH_GAIN_SELECT, osc[3])
      `CHK(EXTERNAL_REFERENCE_SOURCE_SELECT, osc[2])
      `CHK(INTERNAL_REFERENCE_SPEED_SELECT, osc[0])
      `CHK(SLOW_REFERENCE_COARSE_TRIM, slow)
      `CHK({FAST_REFERENCE_TRIM, SLOW_REFERENCE_FINE_TRIM}, {fast, fine})
      `CHK({DCO_RANGE_SELECT, DCO_RANGE_STATUS}, {rng, rng})
      `CHK({DCO_MAX_FREQUENCY_OPTION, FLL_FACTOR}, {mx, fll(rng, mx)})
      `CHK(MODE_REQUEST, exp_mode(CURRENT_MODE))
      `CHK(LOOP_DISABLE, 1'(osc[1] && CURRENT_MODE inside {4'h6, 4'h7}))
      `CHK({LOSS_OF_CLOCK_RESET_REQ, LOSS_OF_CLOCK_IRQ}, {hit && osc[7], hit && !osc[7]})
   endtask : chk_ports
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int k = 0; k < 2; k++) begin
         do_rst();
         for (int a = 1; a < 4; a++) rd(4'(a));
         #1 chk_ports();
         // low-power bit then range write that must be dropped, reserved bit written
         wr(4'h1, 8'hFF, 1'b1);
         wr(4'h3, 8'hE5, 1'b1);
         wr(4'hC, 8'h55, 1'b1);
         rd(4'hC);
         for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            @(posedge SYS_CLK);
            CURRENT_MODE <= 4'(i % 9);
            {EXTERNAL_CLOCK_MONITOR_ENABLE, OSC_CLOCK_LOST} <= r[17:16];
            wr(r[7:5] == 3'h0 ? r[3:0] : {2'h0, r[1:0]}, r[15:8], r[19:18] != 2'h0);
            repeat (5) @(posedge SYS_CLK);
            #1 chk_ports();
            rd(r[7:5] == 3'h0 ? r[3:0] : {2'h0, r[1:0]});
         end
      end
      wrap_up();
   end
endmodule : tb
bind otdrc_ctrl otdrc_ctrl_asserts chk_u (.SYS_CLK, .RST_B, .REG_ADDR, .REG_WR, .REG_RD,
   .REG_SUPERVISOR, .REG_RDATA, .REG_BUS_ERROR, .FACTORY_SLOW_COARSE_TRIM,
   .FACTORY_SLOW_FINE_TRIM, .FACTORY_FAST_TRIM, .SLOW_REFERENCE_COARSE_TRIM,
   .SLOW_REFERENCE_FINE_TRIM, .FAST_REFERENCE_TRIM, .EXTERNAL_CLOCK_MONITOR_ENABLE,
   .OSC_CLOCK_LOST, .CURRENT_MODE, .MODE_REQUEST, .LOOP_DISABLE, .DCO_RANGE_SELECT,
   .DCO_RANGE_STATUS, .DCO_MAX_FREQUENCY_OPTION, .FLL_FACTOR, .LOSS_OF_CLOCK_IRQ,
   .LOSS_OF_CLOCK_RESET_REQ);
